/* sim/sdp_host.sv */
`timescale 1ns/100ps

// ------------------------------------
// serial master in the host's place
// ------------------------------------
module sdp_host
(
  input wire logic mclk, // system clock
  input wire logic so, // resolved serial out line
  output logic sclk, // serial clock, idle low
  output logic chip_select_n, // select, active low
  output logic si // serial data to device
);
  initial
  begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    si = 1'b0;
  end

  // no clock edge until the line is seen low; a slow device just reports not ok
  task automatic open_sel(output logic ok);
    ok = 1'b0;
    @(negedge mclk);
    chip_select_n = 1'b0;
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 8 && !ok; i++)
    begin
      @(negedge mclk);
      ok = (so === 1'b0);
    end
  endtask

  // data set while sclk low, answer taken at the rise
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      si = tx[i];
      repeat (4) @(negedge mclk);
      sclk = 1'b1;
      rx[i] = so;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
  endtask

  // data line flips on release so a stale level is never mistaken for data
  task automatic close_sel();
    repeat (4) @(negedge mclk);
    chip_select_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge mclk);
  endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/100ps

module tb;
  typedef struct {logic [7:0] hdr; logic [7:0] dat; logic [2:0] ms;} sdp_row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic sclk, chip_select_n, si, so_o, so_oe_n, so_w, ok;
  logic so_last = 1'b1;
  logic supply_ready = 1'b1, xosc_running = 1'b1, sleep_state = 1'b0;
  logic crystal_off_state = 1'b0, soft_reset_strobe = 1'b0;
  logic [2:0] main_state = 3'h0;
  logic device_ready_n, reg_we, reg_re, tx_valid, rx_ready;
  logic tx_ready = 1'b1, rx_valid = 1'b0;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_data, wr_a, wr_d, st, rd;
  logic [7:0] rx_data = 8'h00;
  logic [6:0] rx_count = 7'h00;
  logic [7:0] txq[$];
  int n_mismatch = 0, n_tests = 0, wr_n = 0, pop_n = 0, re_n = 0, w0;
  sdp_row_t rows[5] = '{'{8'h05, 8'hA5, 3'h0}, '{8'h2A, 8'h3C, 3'h1}, '{8'h3E, 8'h81, 3'h0},
    '{8'h91, 8'h00, 3'h1}, '{8'h80, 8'h00, 3'h0}};

  // ------------------------------------
  // clock, line and register stand-in
  // ------------------------------------
  always #10 mclk = ~mclk;
  // no pull on the line: released it shows the opposite of its last level
  assign so_w = so_oe_n ? ~so_last : so_o;
  function automatic logic [7:0] exp_rd(input logic [5:0] a);
    return {a, 2'b01};
  endfunction
  assign reg_rdata = exp_rd(reg_addr);

  sdp_port dut_u (.mclk(mclk), .reset(reset), .sclk(sclk), .chip_select_n(chip_select_n),
    .si(si), .so_o(so_o), .so_oe_n(so_oe_n), .supply_ready(supply_ready),
    .xosc_running(xosc_running), .sleep_state(sleep_state),
    .crystal_off_state(crystal_off_state), .soft_reset_strobe(soft_reset_strobe),
    .main_state(main_state), .device_ready_n(device_ready_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_count(rx_count));
  sdp_host host_u (.mclk(mclk), .so(so_w), .sclk(sclk), .chip_select_n(chip_select_n),
    .si(si));

  // user side log: writes, pops, drained words
  always @(posedge mclk)
  begin
    if (so_oe_n === 1'b0)
      so_last <= so_o;
    if (reg_we === 1'b1)
    begin
      wr_n++;
      wr_a = {2'b00, reg_addr};
      wr_d = reg_wdata;
    end
    if (rx_ready === 1'b1)
      pop_n++;
    if (reg_re === 1'b1)
      re_n++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      txq.push_back(tx_data);
  end

  // ------------------------------------
  // compare, access and verdict
  // ------------------------------------
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic single(input logic [7:0] h, input logic [7:0] d);
    host_u.open_sel(ok);
    cmp("ready low", 8'h01, {7'h00, ok});
    host_u.xfer(h, 8, st);
    host_u.xfer(d, 8, rd);
    host_u.close_sel();
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (5) @(negedge mclk);
    cmp("so_oe_n in reset", 8'h01, {7'h00, so_oe_n});
    cmp("tx_valid in reset", 8'h00, {7'h00, tx_valid});
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[i])
    begin
      main_state = rows[i].ms;
      single(rows[i].hdr, rows[i].dat);
      cmp("status", {1'b0, rows[i].ms, 4'hF}, st);
      if (rows[i].hdr[7])
        cmp("read data", exp_rd(rows[i].hdr[5:0]), rd);
      else
      begin
        cmp("write addr", {2'b00, rows[i].hdr[5:0]}, wr_a);
        cmp("write data", rows[i].dat, wr_d);
      end
    end
    cmp("reg reads", 8'h02, 8'(re_n));
    // burst read walks the address up
    host_u.open_sel(ok);
    host_u.xfer(8'hC8, 8, st);
    for (int i = 0; i < 3; i++)
    begin
      host_u.xfer(8'h00, 8, rd);
      cmp("burst read", exp_rd(6'(8 + i)), rd);
    end
    host_u.close_sel();
    // buffer read pops exactly one byte
    rx_valid = 1'b1;
    rx_data = 8'h96;
    rx_count = 7'h14;
    host_u.open_sel(ok);
    host_u.xfer(8'hBF, 8, st);
    host_u.xfer(8'h00, 8, rd);
    host_u.xfer(8'h00, 8, st);
    host_u.close_sel();
    cmp("rx byte", 8'h96, rd);
    cmp("rx pops", 8'h01, 8'(pop_n));
    cmp("rx status", 8'h0F, st);
    // fill the buffer past full with the far side stalled, then drain
    tx_ready = 1'b0;
    host_u.open_sel(ok);
    host_u.xfer(8'h7F, 8, st);
    for (int k = 0; k < 17; k++)
    begin
      host_u.xfer(8'h40 + 8'(k), 8, st);
      if (k == 2 || k == 16)
        cmp("tx free", 8'(16 - k), {4'h0, st[3:0]});
    end
    host_u.close_sel();
    tx_ready = 1'b1;
    repeat (40) @(negedge mclk);
    cmp("tx words", 8'h10, 8'(txq.size()));
    cmp("tx first", 8'h40, txq[0]);
    cmp("tx last", 8'h4F, txq[15]);
    // release mid-byte, then a clean access must still frame right
    w0 = wr_n;
    host_u.open_sel(ok);
    host_u.xfer(8'h07, 8, st);
    host_u.xfer(8'hFF, 4, rd);
    host_u.close_sel();
    cmp("aborted writes", 8'(w0), 8'(wr_n));
    single(8'h07, 8'h5B);
    cmp("write after abort", 8'h5B, wr_d);
    // soft reset holds not-ready until select is released
    host_u.open_sel(ok);
    soft_reset_strobe = 1'b1;
    @(negedge mclk);
    soft_reset_strobe = 1'b0;
    cmp("reset pending", 8'h01, {7'h00, device_ready_n});
    host_u.close_sel();
    cmp("pending cleared", 8'h00, {7'h00, device_ready_n});
    // each of the supply, crystal, sleep and crystal-off causes keeps the line high until it goes away
    for (int c = 0; c < 4; c++)
    begin
      supply_ready = (c != 0);
      xosc_running = (c != 1);
      sleep_state = (c == 2);
      crystal_off_state = (c == 3);
      host_u.open_sel(ok);
      cmp("held high", 8'h00, {7'h00, ok});
      cmp("device_ready_n", 8'h01, {7'h00, device_ready_n});
      supply_ready = 1'b1;
      xosc_running = 1'b1;
      sleep_state = 1'b0;
      crystal_off_state = 1'b0;
      repeat (8) @(negedge mclk);
      cmp("low once ready", 8'h00, {7'h00, so_w});
      host_u.close_sel();
    end
    summarize();
  end
endmodule

/* verilog/sdp_fifo.sv */
`timescale 1ns/100ps
`include "sdp_params.svh"

module sdp_fifo
#(
  parameter int WIDTH = `SDP_DATA_W,
  parameter int DEPTH = `SDP_FIFO_DEPTH,
  parameter int LVL_W = `SDP_LVL_W
)
(
  input wire logic mclk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic in_valid, // write request
  output logic in_ready, // space left
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data waiting
  input wire logic out_ready, // consumer takes a word
  output logic [WIDTH-1:0] out_data, // head word
  output logic [LVL_W-1:0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [LVL_W-1:0] lvl_q, lvl_d;
  logic push, pop;

  // ------------------------------------------------------------
  // pointers and level
  // ------------------------------------------------------------
  // honest full and empty come straight from the level count
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    lvl_d = lvl_q + LVL_W'(push) - LVL_W'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      lvl_q <= lvl_d;
    end
  end

  // storage has no reset; while empty out_data still shows the stale word at rd_q, with out_valid low
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  assign in_ready = (lvl_q != LVL_W'(DEPTH));
  assign out_valid = (lvl_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = lvl_q;
endmodule

/* verilog/sdp_params.svh */
`ifndef SDP_PARAMS_SVH
`define SDP_PARAMS_SVH

// ----------------------------------------------------------------
// header byte layout
// ----------------------------------------------------------------
`define SDP_HDR_RW 7
`define SDP_HDR_BURST 6
`define SDP_ADDR_W 6
// address that reaches the buffered data instead of a register
`define SDP_BUF_ADDR 6'h3F

// ----------------------------------------------------------------
// status byte layout and sizes
// ----------------------------------------------------------------
`define SDP_ST_RDY 7
`define SDP_ST_STATE_LO 4
`define SDP_NIB_MAX 7'h0F
`define SDP_CNT_W 7
`define SDP_DATA_W 8
`define SDP_FIFO_DEPTH 16
`define SDP_LVL_W 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDP_SH_RST 8'hFF
`define SDP_BYTE_RST 8'h00

`endif

/* verilog/sdp_pkg.sv */
package sdp_pkg;
  // serial framing states, one-hot
  typedef enum logic [3:0] {
    SDP_IDLE = 4'h1,
    SDP_WAIT = 4'h2,
    SDP_HDR = 4'h4,
    SDP_DATA = 4'h8
  } sdp_state_t;
endpackage

/* verilog/sdp_port.sv */
`timescale 1ns/100ps
`include "sdp_params.svh"

// Operation
// (R1) device is four-wire serial slave only
// (R2) one port serves registers and buffered data
// (R3) all bytes shift most significant bit first
// (R4) header holds read/write, burst, six-bit address
// (R5) master keeps select low whole access
// (R6) select release abandons partial transfer
// (R7) master waits for output low first
// (R8) output high until supply and crystal ready
// (R9) output low at once unless sleeping/reset
// (R10) status byte returned with every byte; read data bytes return the data instead
// (R11) status: ready_n bit7, state bits 6:4
// (R12) status low nibble: fifo count, saturating 15
// (R13) header bit 6 selects burst access
// (R14) bit7 read flag, bits 5:0 address
// (R15) sample rising, drive falling, reframe on release
module sdp_port
(
  input wire logic mclk, // system clock, 50 MHz
  input wire logic reset, // synchronous, active high
  input wire logic sclk, // serial clock pin
  input wire logic chip_select_n, // select pin, active low
  input wire logic si, // serial data in pin
  output logic so_o, // serial data out value
  output logic so_oe_n, // serial out enable, low drives
  input wire logic supply_ready, // digital regulator stable
  input wire logic xosc_running, // crystal running
  input wire logic sleep_state, // device asleep
  input wire logic crystal_off_state, // crystal switched off
  input wire logic soft_reset_strobe, // one-cycle soft reset
  input wire logic [2:0] main_state, // main state code
  output logic device_ready_n, // low when port may be used
  output logic [`SDP_ADDR_W-1:0] reg_addr, // register address
  output logic [`SDP_DATA_W-1:0] reg_wdata, // register write data
  output logic reg_we, // register write pulse
  output logic reg_re, // register read pulse
  input wire logic [`SDP_DATA_W-1:0] reg_rdata, // read data for reg_addr
  output logic tx_valid, // transmit byte waiting
  input wire logic tx_ready, // transmit byte taken
  output logic [`SDP_DATA_W-1:0] tx_data, // transmit byte
  input wire logic rx_valid, // receive byte waiting
  output logic rx_ready, // receive byte taken
  input wire logic [`SDP_DATA_W-1:0] rx_data, // receive byte
  input wire logic [`SDP_CNT_W-1:0] rx_count // receive bytes held
);
  import sdp_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q, cs_s1_q, cs_s2_q, si_s1_q, si_s2_q;
  logic rise, fall;

  // first stage feeds only the second; edges come from stage two and three
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end
    else
    begin
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= chip_select_n;
      cs_s2_q <= cs_s1_q;
      si_s1_q <= si;
      si_s2_q <= si_s1_q;
    end
  end

  assign rise = sclk_s2_q && !sclk_s3_q;
  assign fall = !sclk_s2_q && sclk_s3_q;

  // saturating count for the status nibble
  function automatic logic [3:0] sat15(input logic [`SDP_CNT_W-1:0] v);
    sat15 = (v > `SDP_NIB_MAX) ? 4'hF : v[3:0];
  endfunction

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  logic push_q, push_d, fifo_in_ready;
  logic [`SDP_LVL_W-1:0] fifo_level;
  logic [`SDP_CNT_W-1:0] free_cnt;

  sdp_fifo #(.WIDTH(`SDP_DATA_W), .DEPTH(`SDP_FIFO_DEPTH), .LVL_W(`SDP_LVL_W)) u_txbuf
  (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .level(fifo_level)
  );

  assign free_cnt = `SDP_CNT_W'(`SDP_FIFO_DEPTH) - `SDP_CNT_W'(fifo_level);

  // ------------------------------------------------------------
  // framing, header decode and byte transfer
  // ------------------------------------------------------------
  sdp_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] in_q, in_d, out_q, out_d, byte_in, status;
  logic [`SDP_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic rw_q, rw_d, burst_q, burst_d, done_q, done_d, we_q, we_d, soft_reset_strobe_q, soft_reset_strobe_d;
  logic not_ready, is_buf, load;

  // soft reset holds the port off until the select is next released
  assign not_ready = !(supply_ready && xosc_running) || sleep_state ||
                     crystal_off_state || soft_reset_strobe_q; // (R8) (R9)
  assign byte_in = {in_q[6:0], si_s2_q};
  assign is_buf = (addr_q == `SDP_BUF_ADDR);
  // header status reports tx space since the direction is not yet known
  assign status = {not_ready, main_state,
                   sat15((st_q == SDP_DATA && rw_q) ? rx_count : free_cnt)}; // (R11) (R12)
  assign load = fall && cnt_q == 3'd0 && (st_q == SDP_HDR || st_q == SDP_DATA);
  assign reg_re = load && st_q == SDP_DATA && rw_q && !done_q && !is_buf;
  assign rx_ready = load && st_q == SDP_DATA && rw_q && !done_q && is_buf && rx_valid; // (R2)

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    in_d = in_q;
    out_d = out_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rw_d = rw_q;
    burst_d = burst_q;
    done_d = done_q;
    we_d = 1'b0;
    push_d = 1'b0;
    soft_reset_strobe_d = soft_reset_strobe || (soft_reset_strobe_q && !cs_s2_q); // (R9)
    unique case (st_q)
      SDP_IDLE:
      begin
        cnt_d = 3'd0; // (R15)
        done_d = 1'b0;
        if (!cs_s2_q)
          st_d = SDP_WAIT;
      end
      SDP_WAIT:
      begin
        if (!not_ready)
        begin
          st_d = SDP_HDR;
          out_d = status; // (R9) (R10)
        end
      end
      default:
      begin
        // sample on rising edges, shift the next bit after falling ones
        if (rise)
        begin
          in_d = byte_in; // (R3) (R15)
          cnt_d = cnt_q + 3'd1;
        end
        if (fall && cnt_q != 3'd0)
          out_d = {out_q[6:0], 1'b0}; // (R3) (R15)
        if (rise && cnt_q == 3'd7 && st_q == SDP_HDR)
        begin
          rw_d = byte_in[`SDP_HDR_RW]; // (R4) (R14)
          burst_d = byte_in[`SDP_HDR_BURST]; // (R13)
          addr_d = byte_in[`SDP_ADDR_W-1:0]; // (R14)
          st_d = SDP_DATA;
        end
        // a write acts only once its eighth bit is in
        if (rise && cnt_q == 3'd7 && st_q == SDP_DATA && !rw_q && !done_q)
        begin
          wdata_d = byte_in;
          we_d = !is_buf; // (R6)
          push_d = is_buf && fifo_in_ready; // (R2)
          done_d = !burst_q; // (R13)
          if (burst_q && !is_buf)
            addr_d = addr_q + 1'b1; // (R13)
        end
        if (load)
        begin
          out_d = status; // (R10)
          if (st_q == SDP_DATA && rw_q && !done_q)
          begin
            out_d = is_buf ? (rx_valid ? rx_data : `SDP_BYTE_RST) : reg_rdata;
            done_d = !burst_q; // (R13)
            if (burst_q && !is_buf)
              addr_d = addr_q + 1'b1;
          end
        end
      end
    endcase
    // release cancels any byte in flight and reframes
    if (cs_s2_q)
      st_d = SDP_IDLE; // (R6) (R15)
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q <= SDP_IDLE;
      cnt_q <= 3'd0;
      in_q <= `SDP_BYTE_RST;
      out_q <= `SDP_SH_RST;
      addr_q <= '0;
      wdata_q <= `SDP_BYTE_RST;
      rw_q <= 1'b0;
      burst_q <= 1'b0;
      done_q <= 1'b0;
      we_q <= 1'b0;
      push_q <= 1'b0;
      soft_reset_strobe_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      in_q <= in_d;
      out_q <= out_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rw_q <= rw_d;
      burst_q <= burst_d;
      done_q <= done_d;
      we_q <= we_d;
      push_q <= push_d;
      soft_reset_strobe_q <= soft_reset_strobe_d;
    end
  end

  // idle or waiting the line is high, so a stale shift bit never fakes a ready low
  assign so_o = (st_q == SDP_IDLE || st_q == SDP_WAIT) ? 1'b1 : out_q[7]; // (R8)
  assign so_oe_n = cs_s2_q; // (R1)
  assign device_ready_n = not_ready; // (R11)
  assign reg_addr = addr_q;
  assign reg_wdata = wdata_q;
  assign reg_we = we_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_wait_so_high: assert property (@(posedge mclk) disable iff (reset) // (R8)
    st_q == SDP_WAIT && not_ready && !cs_s2_q |=> so_o && st_q == SDP_WAIT)
    else $error("serial out not high while waiting");
  a_ready_so_low: assert property (@(posedge mclk) disable iff (reset) // (R9)
    st_q == SDP_WAIT && !not_ready && !cs_s2_q |=> !so_o && st_q == SDP_HDR)
    else $error("serial out not low once ready");
  a_oe_select: assert property (@(posedge mclk) disable iff (reset) // (R1)
    so_oe_n == $past(chip_select_n, 2))
    else $error("output enable does not follow select");
  a_cancel_no_write: assert property (@(posedge mclk) disable iff (reset) // (R6)
    cs_s2_q ##1 cs_s2_q |=> !reg_we && !push_q)
    else $error("write issued after select release");
  a_hdr_fields: assert property (@(posedge mclk) disable iff (reset) // (R4)
    rise && cnt_q == 3'd7 && st_q == SDP_HDR && !cs_s2_q
    |=> reg_addr == $past(byte_in[5:0]) && rw_q == $past(byte_in[7])
        && burst_q == $past(byte_in[6]))
    else $error("header fields not captured");
  a_burst_incr: assert property (@(posedge mclk) disable iff (reset) // (R13)
    reg_we && burst_q |-> reg_addr == $past(reg_addr) + 6'd1)
    else $error("burst address not advanced");
  a_single_once: assert property (@(posedge mclk) disable iff (reset) // (R13)
    reg_we && !burst_q && !cs_s2_q |=> !reg_we [*8])
    else $error("second write in single access");
  a_status_load: assert property (@(posedge mclk) disable iff (reset) // (R11)
    load && !(st_q == SDP_DATA && rw_q && !done_q) && !cs_s2_q
    |=> out_q[6:4] == $past(main_state) && out_q[7] == $past(not_ready))
    else $error("status byte state field wrong");
  a_status_nib: assert property (@(posedge mclk) disable iff (reset) // (R12)
    st_q == SDP_HDR || (st_q == SDP_DATA && !rw_q)
    |-> status[3:0] == ((fifo_level == '0) ? 4'hF
                        : 4'(`SDP_LVL_W'(`SDP_FIFO_DEPTH) - fifo_level)))
    else $error("status nibble not saturated count");
  a_buf_push: assert property (@(posedge mclk) disable iff (reset) // (R2)
    rise && cnt_q == 3'd7 && st_q == SDP_DATA && !rw_q && !done_q && is_buf
    && fifo_in_ready && !cs_s2_q |=> push_q && reg_wdata == $past(byte_in))
    else $error("buffered write not pushed");
  a_sample_rise: assert property (@(posedge mclk) disable iff (reset) // (R15)
    !rise && st_q != SDP_IDLE |=> in_q == $past(in_q))
    else $error("input shifted without rising edge");
endmodule
